// ---- src/fifo_pkg.sv ----
// Shared constants and types for the replay FIFO and its controller
package fifo_pkg;
	localparam int DATA_W = 9;
	localparam int FIFO_DEPTH = 131072;
	// Flag offsets used until software loads its own
	localparam int EMPTY_OFFSET_DEF = 7;
	localparam int FULL_OFFSET_DEF = 7;
	localparam int OFFSET_W = 9;
	// Timing
	localparam int CLK_PERIOD_NS = 25;
	localparam int REPLAY_PULSE_NS = 100;
	localparam int REPLAY_RECOVERY_NS = 100;
	localparam int MRESET_NS = 200;
	localparam int REPLAY_PULSE_CYC =
		(REPLAY_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int REPLAY_RECOVERY_CYC =
		(REPLAY_RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int MRESET_CYC = (MRESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SEQ_CNT_W = 8;
	// Half period of the generated link clocks in pclk cycles (200 ns period)
	localparam int LINK_HALF_DEF = 4;
	localparam int LINK_DIV_W = 8;
	// Controller register map (APB byte addresses)
	localparam int APB_ADDR_W = 8;
	localparam logic [7:0] CFG_ADDR = 8'h00;
	localparam logic [7:0] CMD_ADDR = 8'h04;
	localparam logic [7:0] TX_ADDR = 8'h08;
	localparam logic [7:0] RX_ADDR = 8'h0c;
	localparam logic [7:0] STAT_ADDR = 8'h10;
	// CFG fields
	localparam int CFG_OFFS_BIT = 0;
	localparam int CFG_FL_BIT = 1;
	localparam int CFG_TOKIN_BIT = 2;
	localparam logic [2:0] CFG_RESET = 3'h6;
	// CMD fields (write one to start)
	localparam int CMD_MRST_BIT = 0;
	localparam int CMD_REPLAY_BIT = 1;
	localparam int CMD_READ_BIT = 2;
	// STAT fields
	localparam int ST_FULL_BIT = 0;
	localparam int ST_EMPTY_BIT = 1;
	localparam int ST_AF_BIT = 2;
	localparam int ST_AE_BIT = 3;
	localparam int ST_TOKOUT_BIT = 4;
	localparam int ST_BUSY_BIT = 5;
	localparam int ST_RXV_BIT = 6;
	localparam int ST_TXP_BIT = 7;
	localparam int ST_W = 8;
	typedef enum logic [1:0] {SEQ_IDLE, SEQ_MRESET, SEQ_REPLAY, SEQ_RECOVER}
		seq_state_t;
endpackage

// ---- src/fifo_link_if.sv ----
// Pin-level link between the FIFO device and its controlling logic
`timescale 1ns/1ps
`default_nettype none
interface fifo_link_if;
	logic wclk;
	logic wen_n;
	logic [fifo_pkg::DATA_W-1:0] din;
	logic rclk;
	logic ren_n;
	logic [fifo_pkg::DATA_W-1:0] dout;
	logic full_flag_n;
	logic empty_flag_n;
	logic almost_full_flag_n;
	logic almost_empty_flag_n;
	logic replay_pulse;
	logic offset_access_n;
	logic first_load_n;
	logic token_in_n;
	logic token_out_n;
	logic master_reset_n;
	modport device_mp (
		input wclk, wen_n, din, rclk, ren_n, replay_pulse, offset_access_n,
		input first_load_n, token_in_n, master_reset_n,
		output dout, full_flag_n, empty_flag_n, almost_full_flag_n,
		output almost_empty_flag_n, token_out_n
	);
	modport ctrl_mp (
		output wclk, wen_n, din, rclk, ren_n, replay_pulse, offset_access_n,
		output first_load_n, token_in_n, master_reset_n,
		input dout, full_flag_n, empty_flag_n, almost_full_flag_n,
		input almost_empty_flag_n, token_out_n
	);
endinterface
`default_nettype wire

// ---- src/bit_sync.sv ----
// Two-flop synchroniser for a vector of independent levels
`timescale 1ns/1ps
`default_nettype none
module bit_sync #(
	parameter int W = 1
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_reg;

	// First stage feeds only the second stage
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_reg <= '0;
			q <= '0;
		end else begin
			meta_reg <= d;
			q <= meta_reg;
		end
	end
endmodule
`default_nettype wire

// ---- src/fifo_device.sv ----
// Deep synchronous 9-bit FIFO with replay, flag offsets and token cascade
//
// How it works
// - Almost-empty defaults to seven words offset
// - Almost-full defaults to seven words offset
// - Replay ignored when cascaded for depth
// - Replay only after reads, within depth
// - Replay pulse returns read pointer to zero
// - Both link clocks stopped around replay
// - Replayed reads advance until pointers meet
// - Replay recomputes every flag from pointers
// - Later writes follow replay; repeatable
// - Width slices share all input controls
// - Outside logic combines empty and full
// - Partial flags taken from any slice
// - Read enable may be tied active
// - Offset pin low at reset selects offsets
// - First cascade device has first-load low
// - Other cascade devices hold first-load high
// - Token out drives next token in
// - Cascade empty/full flags ORed outside
// - Full flag blocks writes, write-clock only; replay and master reset also update it here
// - Empty flag blocks reads, read-clock only; replay and master reset also update it here
// - Almost-full at capacity minus full offset
`timescale 1ns/1ps
`default_nettype none
module fifo_device #(
	parameter int DEPTH = fifo_pkg::FIFO_DEPTH
) (
	input wire logic pclk,
	input wire logic presetn,
	fifo_link_if.device_mp link,
	output logic [$clog2(fifo_pkg::FIFO_DEPTH):0] fill_level,
	output logic offset_mode,
	output logic depth_cascade
);
	import fifo_pkg::*;

	localparam int AW = $clog2(DEPTH);
	localparam int SW = 5 + DATA_W + 4;
	localparam logic [AW:0] DEPTH_V = (AW + 1)'(DEPTH);
	localparam logic [AW-1:0] LAST_LOC = AW'(DEPTH - 1);

	logic [SW-1:0] pin_raw;
	logic [SW-1:0] pin_s;
	logic wclk_s, rclk_s, wen_s, ren_s, rt_s, ld_s, fl_s, tok_s, mr_s;
	logic [DATA_W-1:0] din_s;
	logic wclk_prev, rclk_prev, rt_prev;
	logic w_rise, r_rise, replay_go, mr_active, offset_load;
	logic wr_ok, rd_ok;
	logic [AW:0] wptr_reg, rptr_reg, wptr_next, rptr_next, occ_next;
	logic [OFFSET_W-1:0] empty_off_reg, full_off_reg;
	logic off_sel_reg;
	logic cascade_reg, offset_mode_reg, wtok_reg, tok_out_reg;
	logic full_reg, empty_reg, af_reg, ae_reg;
	logic [DATA_W-1:0] dout_reg;
	logic [DATA_W-1:0] mem [DEPTH];

	// Every link input is asynchronous to pclk, so all pass two flops
	assign pin_raw = {link.wclk, link.rclk, link.wen_n, link.ren_n,
		link.replay_pulse, link.din, link.offset_access_n, link.first_load_n,
		link.token_in_n, link.master_reset_n};
	bit_sync #(.W(SW)) u_sync (
		.pclk(pclk),
		.presetn(presetn),
		.d(pin_raw),
		.q(pin_s)
	);
	assign {wclk_s, rclk_s, wen_s, ren_s, rt_s, din_s, ld_s, fl_s, tok_s,
		mr_s} = pin_s;

	// Edge detectors on the synchronised link clocks and replay level
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wclk_prev <= 1'b0;
			rclk_prev <= 1'b0;
			rt_prev <= 1'b0;
		end else begin
			wclk_prev <= wclk_s;
			rclk_prev <= rclk_s;
			rt_prev <= rt_s;
		end
	end

	// Synced master reset idles low out of reset, so the FIFO starts cleared
	assign mr_active = ~mr_s;
	assign w_rise = wclk_s & ~wclk_prev;
	assign r_rise = rclk_s & ~rclk_prev;
	assign replay_go = rt_s & ~rt_prev & ~cascade_reg & ~mr_active;
	assign offset_load = offset_mode_reg & ~ld_s;

	// Writes need space and, in a cascade, the write token
	assign wr_ok = w_rise & ~wen_s & full_reg & ~offset_load & ~mr_active &
		(~cascade_reg | wtok_reg);
	assign rd_ok = r_rise & ~ren_s & empty_reg & ~mr_active &
		~replay_go;

	// Pointer next values; the extra top bit separates full from empty
	always_comb begin
		wptr_next = wptr_reg;
		rptr_next = rptr_reg;
		if (mr_active) begin
			wptr_next = '0;
			rptr_next = '0;
		end else begin
			if (wr_ok) begin
				wptr_next = wptr_reg + (AW + 1)'(1);
			end
			if (replay_go) begin
				rptr_next = '0;
			end else if (rd_ok) begin
				rptr_next = rptr_reg + (AW + 1)'(1);
			end
		end
		occ_next = wptr_next - rptr_next;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wptr_reg <= '0;
			rptr_reg <= '0;
		end else begin
			wptr_reg <= wptr_next;
			rptr_reg <= rptr_next;
		end
	end

	// Storage; no reset so the array can map to RAM
	always_ff @(posedge pclk) begin
		if (wr_ok) begin
			mem[wptr_reg[AW-1:0]] <= din_s;
		end
	end

	// Read port: data is held until the next accepted read
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dout_reg <= '0;
		end else if (rd_ok) begin
			dout_reg <= mem[rptr_reg[AW-1:0]];
		end
	end

	// Straps caught while master reset is held
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cascade_reg <= 1'b0;
			offset_mode_reg <= 1'b0;
		end else if (mr_active) begin
			cascade_reg <= tok_s;
			offset_mode_reg <= ~ld_s;
		end
	end

	// Offset loading: empty offset first, then full offset, alternating
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			empty_off_reg <= OFFSET_W'(EMPTY_OFFSET_DEF);
			full_off_reg <= OFFSET_W'(FULL_OFFSET_DEF);
			off_sel_reg <= 1'b0;
		end else if (mr_active) begin
			empty_off_reg <= OFFSET_W'(EMPTY_OFFSET_DEF);
			full_off_reg <= OFFSET_W'(FULL_OFFSET_DEF);
			off_sel_reg <= 1'b0;
		end else if (offset_load && w_rise && !wen_s) begin
			if (off_sel_reg) begin
				full_off_reg <= din_s;
			end else begin
				empty_off_reg <= din_s;
			end
			off_sel_reg <= ~off_sel_reg;
		end
	end

	// Write-side flags: change only on write clock edges, at replay or at master reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			full_reg <= 1'b1;
			af_reg <= 1'b1;
		end else if (mr_active) begin
			full_reg <= 1'b1;
			af_reg <= 1'b1;
		end else if (w_rise || replay_go) begin
			full_reg <= (occ_next != DEPTH_V);
			af_reg <= (occ_next < DEPTH_V - (AW + 1)'(full_off_reg));
		end
	end

	// Read-side flags: change only on read clock edges, at replay or at master reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			empty_reg <= 1'b0;
			ae_reg <= 1'b0;
		end else if (mr_active) begin
			empty_reg <= 1'b0;
			ae_reg <= 1'b0;
		end else if (r_rise || replay_go) begin
			empty_reg <= (occ_next != '0);
			ae_reg <= (occ_next > (AW + 1)'(empty_off_reg));
		end
	end

	// Write token: the device holding it writes until its last location,
	// then passes it on with a low token-out lasting one write clock
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wtok_reg <= 1'b0;
			tok_out_reg <= 1'b1;
		end else if (mr_active) begin
			wtok_reg <= ~fl_s;
			tok_out_reg <= 1'b1;
		end else if (cascade_reg) begin
			if (wr_ok && wptr_reg[AW-1:0] == LAST_LOC) begin
				wtok_reg <= 1'b0;
				tok_out_reg <= 1'b0;
			end else if (w_rise) begin
				tok_out_reg <= 1'b1;
				if (!tok_s) begin
					wtok_reg <= 1'b1;
				end
			end
		end
	end

	assign link.dout = dout_reg;
	assign link.full_flag_n = full_reg;
	assign link.empty_flag_n = empty_reg;
	assign link.almost_full_flag_n = af_reg;
	assign link.almost_empty_flag_n = ae_reg;
	assign link.token_out_n = tok_out_reg;
	assign fill_level = ($clog2(FIFO_DEPTH) + 1)'(wptr_reg - rptr_reg);
	assign offset_mode = offset_mode_reg;
	assign depth_cascade = cascade_reg;
endmodule
`default_nettype wire

// ---- src/fifo_controller.sv ----
// APB-programmed controller that writes, reads and replays the FIFO
`timescale 1ns/1ps
`default_nettype none
module fifo_controller #(
	parameter int LINK_HALF = fifo_pkg::LINK_HALF_DEF
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [fifo_pkg::APB_ADDR_W-1:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	fifo_link_if.ctrl_mp link
);
	import fifo_pkg::*;

	localparam int FW = ST_W - 3;
	logic [FW-1:0] flag_raw, flag_s;
	logic [DATA_W-1:0] dout_s;
	logic [2:0] cfg_reg;
	logic [DATA_W-1:0] tx_data_reg, rx_data_reg, din_reg;
	logic tx_pend_reg, rx_req_reg, rx_valid_reg, rd_wait_reg;
	logic wen_n_reg, ren_n_reg;
	seq_state_t state_reg;
	logic [SEQ_CNT_W-1:0] seq_cnt_reg;
	logic run;
	logic [1:0] lclk_reg, fall;
	logic [LINK_DIV_W-1:0] div_reg [2];
	logic wr_acc, rd_acc, mapped, seq_start;
	logic [31:0] rd_mux;

	// Returned flags and data are asynchronous to pclk
	// One slice only, so its own flags are the composite ones
	// and no ORing across devices is needed here
	assign flag_raw = {link.token_out_n, link.almost_empty_flag_n,
		link.almost_full_flag_n, link.empty_flag_n, link.full_flag_n};
	bit_sync #(.W(FW + DATA_W)) u_sync (
		.pclk(pclk),
		.presetn(presetn),
		.d({flag_raw, link.dout}),
		.q({flag_s, dout_s})
	);

	assign wr_acc = psel & penable & pwrite;
	assign rd_acc = psel & penable & ~pwrite;
	assign mapped = (paddr == CFG_ADDR) || (paddr == CMD_ADDR) ||
		(paddr == TX_ADDR) || (paddr == RX_ADDR) || (paddr == STAT_ADDR);
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~mapped;
	assign run = (state_reg == SEQ_IDLE);
	// A write that starts a reset or replay stops the link clocks at once,
	// so no clock level or edge overlaps the pulse
	assign seq_start = run & wr_acc & (paddr == CMD_ADDR) &
		(pwdata[CMD_MRST_BIT] | pwdata[CMD_REPLAY_BIT]);

	// Link clock dividers; held low while a replay or reset is in progress
	for (genvar i = 0; i < 2; i++) begin : g_div
		assign fall[i] = run & lclk_reg[i] &
			(div_reg[i] == LINK_DIV_W'(LINK_HALF - 1));
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				div_reg[i] <= '0;
				lclk_reg[i] <= 1'b0;
			end else if (!run || seq_start) begin
				div_reg[i] <= '0;
				lclk_reg[i] <= 1'b0;
			end else if (div_reg[i] == LINK_DIV_W'(LINK_HALF - 1)) begin
				div_reg[i] <= '0;
				lclk_reg[i] <= ~lclk_reg[i];
			end else begin
				div_reg[i] <= div_reg[i] + LINK_DIV_W'(1);
			end
		end
	end

	// Sequencer for master reset and replay, both with a recovery gap
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= SEQ_IDLE;
			seq_cnt_reg <= '0;
		end else begin
			case (state_reg)
				SEQ_IDLE: begin
					if (wr_acc && paddr == CMD_ADDR && pwdata[CMD_MRST_BIT]) begin
						state_reg <= SEQ_MRESET;
						seq_cnt_reg <= SEQ_CNT_W'(MRESET_CYC - 1);
					end else if (wr_acc && paddr == CMD_ADDR &&
						pwdata[CMD_REPLAY_BIT]) begin
						state_reg <= SEQ_REPLAY;
						seq_cnt_reg <= SEQ_CNT_W'(REPLAY_PULSE_CYC - 1);
					end
				end
				SEQ_MRESET, SEQ_REPLAY: begin
					if (seq_cnt_reg == '0) begin
						state_reg <= SEQ_RECOVER;
						seq_cnt_reg <= SEQ_CNT_W'(REPLAY_RECOVERY_CYC - 1);
					end else begin
						seq_cnt_reg <= seq_cnt_reg - SEQ_CNT_W'(1);
					end
				end
				SEQ_RECOVER: begin
					if (seq_cnt_reg == '0) begin
						state_reg <= SEQ_IDLE;
					end else begin
						seq_cnt_reg <= seq_cnt_reg - SEQ_CNT_W'(1);
					end
				end
				default: state_reg <= SEQ_IDLE;
			endcase
		end
	end

	// Strap configuration
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_reg <= CFG_RESET;
		end else if (wr_acc && paddr == CFG_ADDR) begin
			cfg_reg <= pwdata[2:0];
		end
	end

	// Write path: enable low for one write clock period, then one high,
	// so the full flag seen at the next check is already up to date
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_pend_reg <= 1'b0;
			tx_data_reg <= '0;
			wen_n_reg <= 1'b1;
			din_reg <= '0;
		end else if (state_reg == SEQ_MRESET) begin
			tx_pend_reg <= 1'b0;
			wen_n_reg <= 1'b1;
		end else begin
			if (fall[0] && !wen_n_reg) begin
				wen_n_reg <= 1'b1;
			end else if (fall[0] && tx_pend_reg && flag_s[ST_FULL_BIT]) begin
				wen_n_reg <= 1'b0;
				din_reg <= tx_data_reg;
				tx_pend_reg <= 1'b0;
			end
			// Own if, so a link clock fall in the same cycle never drops it
			if (wr_acc && paddr == TX_ADDR && !tx_pend_reg) begin
				tx_data_reg <= pwdata[DATA_W-1:0];
				tx_pend_reg <= 1'b1;
			end
		end
	end

	// Read path: data is taken one and a half read clock periods after the rising edge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_req_reg <= 1'b0;
			ren_n_reg <= 1'b1;
			rd_wait_reg <= 1'b0;
			rx_valid_reg <= 1'b0;
			rx_data_reg <= '0;
		end else if (state_reg == SEQ_MRESET) begin
			rx_req_reg <= 1'b0;
			ren_n_reg <= 1'b1;
			rd_wait_reg <= 1'b0;
			rx_valid_reg <= 1'b0;
		end else begin
			if (wr_acc && paddr == CMD_ADDR && pwdata[CMD_READ_BIT]) begin
				rx_req_reg <= 1'b1;
			end
			if (fall[1] && !ren_n_reg) begin
				ren_n_reg <= 1'b1;
				rd_wait_reg <= 1'b1;
			end else if (fall[1] && rd_wait_reg) begin
				rd_wait_reg <= 1'b0;
				rx_data_reg <= dout_s;
			end else if (fall[1] && rx_req_reg && flag_s[ST_EMPTY_BIT]) begin
				ren_n_reg <= 1'b0;
				rx_req_reg <= 1'b0;
			end
			// Capture sets valid and wins over a clearing read of RX
			if (fall[1] && rd_wait_reg) begin
				rx_valid_reg <= 1'b1;
			end else if (rd_acc && paddr == RX_ADDR) begin
				rx_valid_reg <= 1'b0;
			end
		end
	end

	// Read data is registered in the setup cycle, ready for the access
	always_comb begin
		rd_mux = '0;
		case (paddr)
			CFG_ADDR: rd_mux[2:0] = cfg_reg;
			RX_ADDR: rd_mux[DATA_W-1:0] = rx_data_reg;
			TX_ADDR: rd_mux[DATA_W-1:0] = tx_data_reg;
			STAT_ADDR: begin
				rd_mux[FW-1:0] = flag_s;
				rd_mux[ST_BUSY_BIT] = ~run;
				rd_mux[ST_RXV_BIT] = rx_valid_reg;
				rd_mux[ST_TXP_BIT] = tx_pend_reg;
			end
			default: rd_mux = '0;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= '0;
		end else if (psel && !penable) begin
			prdata <= rd_mux;
		end
	end

	assign link.wclk = lclk_reg[0];
	assign link.rclk = lclk_reg[1];
	assign link.wen_n = wen_n_reg;
	assign link.ren_n = ren_n_reg;
	assign link.din = din_reg;
	assign link.replay_pulse = (state_reg == SEQ_REPLAY);
	assign link.master_reset_n = (state_reg != SEQ_MRESET);
	assign link.offset_access_n = cfg_reg[CFG_OFFS_BIT];
	assign link.first_load_n = cfg_reg[CFG_FL_BIT];
	assign link.token_in_n = cfg_reg[CFG_TOKIN_BIT];
endmodule
`default_nettype wire

// ---- dv/fifo_link_props.sv ----
// Assertions on the link between the FIFO device and its controller
`timescale 1ns/1ps
`default_nettype none
module fifo_link_props (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic wclk,
	input wire logic rclk,
	input wire logic full_flag_n,
	input wire logic empty_flag_n,
	input wire logic almost_full_flag_n,
	input wire logic almost_empty_flag_n,
	input wire logic replay_pulse,
	input wire logic master_reset_n
);
	logic [3:0] wq_reg;
	logic [3:0] rq_reg;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Cycles since a write-side cause; the device needs a few to sync the pin
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wq_reg <= 4'h0;
		end else if ($rose(wclk) || replay_pulse || !master_reset_n) begin
			wq_reg <= 4'h0;
		end else if (wq_reg != 4'hf) begin
			wq_reg <= wq_reg + 4'h1;
		end
	end
	// Same for the read side
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rq_reg <= 4'h0;
		end else if ($rose(rclk) || replay_pulse || !master_reset_n) begin
			rq_reg <= 4'h0;
		end else if (rq_reg != 4'hf) begin
			rq_reg <= rq_reg + 4'h1;
		end
	end
	a_pulse_width: assert property (
		$rose(replay_pulse) |-> replay_pulse[*4] ##1 !replay_pulse)
		else $error("replay pulse width wrong");
	a_clocks_held: assert property (
		replay_pulse |-> !wclk && !rclk)
		else $error("link clock ran during replay");
	a_recovery_quiet: assert property (
		$fell(replay_pulse) |-> (!wclk && !rclk)[*4])
		else $error("link clock ran during replay recovery");
	a_mreset_width: assert property (
		$fell(master_reset_n) |-> !master_reset_n[*8] ##1 master_reset_n)
		else $error("master reset width wrong");
	a_full_in_af: assert property (
		!full_flag_n |-> !almost_full_flag_n)
		else $error("full without almost full");
	a_empty_in_ae: assert property (
		!empty_flag_n |-> !almost_empty_flag_n)
		else $error("empty without almost empty");
	a_never_both: assert property (
		!(!full_flag_n && !empty_flag_n))
		else $error("full and empty together");
	a_full_on_wclk: assert property (
		$changed(full_flag_n) |-> wq_reg <= 4'd6)
		else $error("full flag moved without write clock");
	a_af_on_wclk: assert property (
		$changed(almost_full_flag_n) |-> wq_reg <= 4'd6)
		else $error("almost full moved without write clock");
	a_empty_on_rclk: assert property (
		$changed(empty_flag_n) |-> rq_reg <= 4'd6)
		else $error("empty flag moved without read clock");
	c_replay: cover property ($rose(replay_pulse));
	c_full: cover property ($fell(full_flag_n));
	c_drain: cover property ($fell(empty_flag_n));
endmodule
`default_nettype wire

// ---- dv/deep_fifo_replay_and_cascade_tb_top.sv ----
// Bench: APB-driven controller filling, replaying and draining the FIFO
`timescale 1ns/1ps
`default_nettype none
module deep_fifo_replay_and_cascade_tb_top;
	import fifo_pkg::*;
	localparam int D = 32;
	localparam int LIMIT = 20000;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [$clog2(FIFO_DEPTH):0] fill_level;
	logic offset_mode;
	logic depth_cascade;
	logic [31:0] rd;
	logic err;
	int failures = 0;
	int checks_done = 0;
	int cycles = 0;
	fifo_link_if fifo_link_if_i ();
	// Small depth so the full boundary is reached in a short run
	fifo_device #(.DEPTH(D)) fifo_device_i (.pclk(pclk), .presetn(presetn),
		.link(fifo_link_if_i.device_mp), .fill_level(fill_level),
		.offset_mode(offset_mode), .depth_cascade(depth_cascade));
	fifo_controller fifo_controller_i (.pclk(pclk), .presetn(presetn),
		.paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.link(fifo_link_if_i.ctrl_mp));
	fifo_link_props fifo_link_props_i (.pclk(pclk), .presetn(presetn),
		.wclk(fifo_link_if_i.wclk), .rclk(fifo_link_if_i.rclk),
		.full_flag_n(fifo_link_if_i.full_flag_n),
		.empty_flag_n(fifo_link_if_i.empty_flag_n),
		.almost_full_flag_n(fifo_link_if_i.almost_full_flag_n),
		.almost_empty_flag_n(fifo_link_if_i.almost_empty_flag_n),
		.replay_pulse(fifo_link_if_i.replay_pulse),
		.master_reset_n(fifo_link_if_i.master_reset_n));
	// Clock and hang guard
	always #12.5 pclk = ~pclk;
	always @(posedge pclk) begin
		cycles++;
		if (cycles == LIMIT) begin
			failures++;
			report_and_stop();
		end
	end
	task automatic report_and_stop();
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			failures++;
			$display("mismatch at %0t: got %h exp %h", $time, got, exp);
		end
	endtask
	// One APB transfer; ends an edge later so no signal is driven twice
	task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] wd);
		psel <= 1'b1;
		penable <= 1'b0;
		paddr <= a;
		pwrite <= w;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	// Status crosses synchronisers, so re-read until it settles
	task automatic poll(input int b, input logic v);
		int n = 0;
		apb(STAT_ADDR, 1'b0, 32'h0);
		while (rd[b] !== v && n < 60) begin
			apb(STAT_ADDR, 1'b0, 32'h0);
			n++;
		end
		chk({31'h0, rd[b]}, {31'h0, v});
	endtask
	task automatic flags(input int n);
		logic [3:0] e;
		int k;
		e = {n > EMPTY_OFFSET_DEF, n < D - FULL_OFFSET_DEF, n != 0, n != D};
		k = 0;
		apb(STAT_ADDR, 1'b0, 32'h0);
		while (rd[3:0] !== e && k < 60) begin
			apb(STAT_ADDR, 1'b0, 32'h0);
			k++;
		end
		chk({28'h0, rd[3:0]}, {28'h0, e});
		chk(32'(fill_level), n);
	endtask
	task automatic put(input logic [31:0] w);
		apb(TX_ADDR, 1'b1, w);
		poll(ST_TXP_BIT, 1'b0);
		// The word leaves on a link clock fall and lands about a period later
		repeat (2 * LINK_HALF_DEF + 4) @(posedge pclk);
	endtask
	task automatic get(input logic [31:0] e);
		apb(CMD_ADDR, 1'b1, 32'h1 << CMD_READ_BIT);
		poll(ST_RXV_BIT, 1'b1);
		apb(RX_ADDR, 1'b0, 32'h0);
		chk(rd, e);
	endtask
	task automatic cmd_wait(input int b);
		apb(CMD_ADDR, 1'b1, 32'h1 << b);
		poll(ST_BUSY_BIT, 1'b0);
	endtask
	task automatic restart(input logic [31:0] cfg);
		apb(CFG_ADDR, 1'b1, cfg);
		cmd_wait(CMD_MRST_BIT);
	endtask
	// Main sequence
	initial begin
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(CFG_ADDR, 1'b0, 32'h0);
		chk(rd, {29'h0, CFG_RESET});
		apb(8'h20, 1'b0, 32'h0);
		chk({31'h0, err}, 32'h1);
		$display("test registers done");
		restart(32'h0);
		chk({31'h0, offset_mode}, 32'h1);
		put(32'h3);
		flags(0);
		$display("test offset mode done");
		restart(32'h1);
		chk({31'h0, offset_mode}, 32'h0);
		chk({31'h0, depth_cascade}, 32'h0);
		flags(0);
		for (int i = 1; i <= D; i++) begin
			put(i);
			flags(i);
		end
		for (int i = 1; i <= 3; i++) begin
			get(i);
		end
		flags(D - 3);
		cmd_wait(CMD_REPLAY_BIT);
		flags(D);
		for (int i = 1; i <= D; i++) begin
			get(i);
		end
		flags(0);
		cmd_wait(CMD_REPLAY_BIT);
		flags(D);
		// A word offered while full stays queued and nothing is stored
		apb(TX_ADDR, 1'b1, 32'h1ff);
		repeat (4 * LINK_HALF_DEF) @(posedge pclk);
		poll(ST_TXP_BIT, 1'b1);
		flags(D);
		get(1);
		$display("test full depth replay done");
		restart(32'h1);
		for (int i = 0; i < 5; i++) begin
			put(32'h10 + i);
		end
		get(32'h10);
		get(32'h11);
		cmd_wait(CMD_REPLAY_BIT);
		flags(5);
		put(32'h20);
		put(32'h21);
		flags(7);
		for (int i = 0; i < 5; i++) begin
			get(32'h10 + i);
		end
		get(32'h20);
		get(32'h21);
		flags(0);
		$display("test writes after replay done");
		restart(32'h5);
		chk({31'h0, depth_cascade}, 32'h1);
		put(32'h1);
		put(32'h2);
		get(32'h1);
		cmd_wait(CMD_REPLAY_BIT);
		flags(1);
		$display("test cascade replay done");
		report_and_stop();
	end
endmodule
`default_nettype wire
